// file: dv/brs_chk.sv
// Port checker for brs_top.
// Shadows the relay word and the high threshold field from APB writes it sees.
// Assumes it is bound into brs_top and sees only that module's ports.
`timescale 1ns/10ps
module brs_chk
	import brs_pkg::*;
#(
	parameter int NCH = 2
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Line and rails
	input wire brs_status_t i_line_status [NCH],
	input wire logic o_rail_select_out_ch_a,
	input wire logic o_rail_select_out_ch_b,
	input wire logic o_ringing_rail_switch_out
);
	logic [7:0] rly_r;
	logic [7:0] hth_r;
	logic acc, wr, map, ring;
	assign acc = i_psel && i_penable;
	assign wr = acc && i_pwrite;
	assign map = i_paddr == BRS_RELAY_ADDR || (i_paddr >= BRS_HTH_ADDR && i_paddr <= BRS_VOLT_B_ADDR);
	assign ring = i_line_status[0].ring_active || i_line_status[1].ring_active;
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rly_r <= BRS_RELAY_RST;
			hth_r <= 8'h00;
		end else if (wr && i_paddr == BRS_RELAY_ADDR) begin
			rly_r <= i_pwdata[7:0];
		end else if (wr && i_paddr == BRS_HTH_ADDR) begin
			hth_r <= i_pwdata[14:7];
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	ready_hi_a: assert property (o_pready) else $error("pready low");
	bad_addr_a: assert property (acc && !map |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
		else $error("unmapped access");
	hth_read_a: assert property (acc && !i_pwrite && i_paddr == BRS_HTH_ADDR |-> o_prdata == {17'h0, hth_r, 7'h0})
		else $error("threshold readback");
	idle_hi_a: assert property (rly_r[BRS_AUTO_BIT] && i_line_status[0].line != BRS_LINE_OFFHOOK
		|=> o_rail_select_out_ch_a) else $error("channel a off high rail");
	idle_hi_b_a: assert property (rly_r[BRS_AUTO_BIT] && i_line_status[1].line != BRS_LINE_OFFHOOK
		|=> o_rail_select_out_ch_b) else $error("channel b off high rail");
	manual_sel_a: assert property (!rly_r[BRS_AUTO_BIT] |=> o_rail_select_out_ch_a == $past(rly_r[5])
		&& o_rail_select_out_ch_b == $past(rly_r[5])) else $error("manual select");
	ring_on_a: assert property (rly_r[BRS_THIRD_RAIL_PRESENT_BIT] |=> o_ringing_rail_switch_out == $past(ring))
		else $error("ringing switch");
	ring_off_a: assert property (!rly_r[BRS_THIRD_RAIL_PRESENT_BIT] |=> !o_ringing_rail_switch_out)
		else $error("ringing switch without rail");
endmodule
bind brs_top brs_chk #(.NCH(NCH)) chk (.i_core_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_line_status, .o_rail_select_out_ch_a,
	.o_rail_select_out_ch_b, .o_ringing_rail_switch_out);

// file: dv/brs_rail_model.sv
// Far-side switch model: which rail feeds each channel.
// Codes: 0 low rail, 1 high rail, 2 ringing rail.
`timescale 1ns/10ps
module brs_rail_model (
	// Switch controls
	input wire logic i_sel_a,
	input wire logic i_sel_b,
	input wire logic i_ring,
	// Rail per channel
	output logic [1:0] o_rail_a,
	output logic [1:0] o_rail_b
);
	assign o_rail_a = i_ring ? 2'h2 : {1'b0, i_sel_a};
	assign o_rail_b = i_ring ? 2'h2 : {1'b0, i_sel_b};
endmodule

// file: dv/brs_top_tb.sv
// Testbench for brs_top with an APB master and the rail model.
// Filter runs every 4 cycles to keep the run short.
`timescale 1ns/10ps
module brs_top_tb;
	import brs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic rdy, err, sa, sb, rg;
	logic [1:0] ra, rb;
	logic [15:0] volt [2] = '{default: 16'h0000};
	brs_status_t st [2] = '{default: '0};
	int errors = 0;
	int checks = 0;
	always #2.5 clk = ~clk;
	brs_top #(.SAMPLE_CYC(4)) uut (.i_core_clk(clk), .i_resetn(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
		.i_tip_ring_volt(volt), .i_line_status(st), .o_rail_select_out_ch_a(sa),
		.o_rail_select_out_ch_b(sb), .o_ringing_rail_switch_out(rg));
	brs_rail_model far (.i_sel_a(sa), .i_sel_b(sb), .i_ring(rg), .o_rail_a(ra), .o_rail_b(rb));
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// A read compares against d, so every read is also a check
	task automatic apb(input string nm, input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (rdy !== 1'b1) begin
			errors++;
			finish_test();
		end else begin
			if (!w) chk(nm, d, prd);
			if (a == 12'h040) chk("slave error", 32'h1, {31'h0, err});
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	task automatic rails(input logic [1:0] ea, input logic [1:0] eb, input int n);
		int i;
		repeat (n) @(posedge clk);
		for (i = 0; i < 40 && (ra !== ea || rb !== eb); i++) @(posedge clk);
		chk("rail a", {30'h0, ea}, {30'h0, ra});
		chk("rail b", {30'h0, eb}, {30'h0, rb});
		// A wait that ran out has already been counted; stop the run there
		if (ra !== ea || rb !== eb) finish_test();
	endtask
	task automatic t_regs();
		apb("relay", 1'b0, BRS_RELAY_ADDR, 32'h21);
		apb("coef", 1'b0, BRS_LPF_ADDR, {16'h0, BRS_LPF_RST});
		apb("unmapped", 1'b0, 12'h040, 32'h0);
		apb("", 1'b1, BRS_HTH_ADDR, 32'hffff);
		apb("high th", 1'b0, BRS_HTH_ADDR, 32'h7f80);
		apb("", 1'b1, BRS_LPF_ADDR, 32'h4007);
		apb("coef", 1'b0, BRS_LPF_ADDR, 32'h4000);
	endtask
	task automatic t_auto();
		apb("", 1'b1, BRS_HTH_ADDR, 32'h2000);
		apb("", 1'b1, BRS_LTH_ADDR, 32'h0800);
		// Let the filter settle on-hook first, so off-hook entry sees a mid-band voltage
		volt[0] <= 16'h1000;
		rails(2'h1, 2'h1, 8);
		st[0].line <= BRS_LINE_OFFHOOK;
		rails(2'h1, 2'h1, 16);
		volt[0] <= 16'h0800;
		rails(2'h0, 2'h1, 0);
		volt[0] <= 16'h1000;
		rails(2'h0, 2'h1, 16);
		volt[0] <= 16'h2000;
		rails(2'h1, 2'h1, 0);
		volt[0] <= 16'h0800;
		rails(2'h0, 2'h1, 0);
		st[0].line <= BRS_LINE_RINGING;
		rails(2'h1, 2'h1, 0);
		st[0].line <= BRS_LINE_OFFHOOK;
		rails(2'h0, 2'h1, 0);
		st[0].line <= BRS_LINE_OHT;
		rails(2'h1, 2'h1, 0);
	endtask
	task automatic t_block();
		apb("", 1'b1, BRS_LPF_ADDR, 32'h0);
		st[0].line <= BRS_LINE_OFFHOOK;
		volt[0] <= 16'h3000;
		rails(2'h0, 2'h1, 16);
		apb("filt a", 1'b0, BRS_VOLT_A_ADDR, 32'h0800);
		st[0].line <= BRS_LINE_ONHOOK;
		apb("", 1'b1, BRS_LPF_ADDR, 32'h4000);
	endtask
	task automatic t_manual();
		apb("", 1'b1, BRS_RELAY_ADDR, 32'h00);
		rails(2'h0, 2'h0, 0);
		apb("", 1'b1, BRS_RELAY_ADDR, 32'h20);
		rails(2'h1, 2'h1, 0);
	endtask
	task automatic t_ring();
		apb("", 1'b1, BRS_RELAY_ADDR, 32'h03);
		st[1].ring_active <= 1'b1;
		rails(2'h2, 2'h2, 0);
		apb("state", 1'b0, BRS_STATE_ADDR, 32'h0000000b);
		apb("", 1'b1, BRS_RELAY_ADDR, 32'h01);
		rails(2'h1, 2'h1, 0);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_auto();
		t_block();
		t_manual();
		t_ring();
		finish_test();
	end
endmodule

// file: rtl/brs_lpf.sv
// Single-pole low-pass filter for one channel's tip-ring voltage.
// Assumes samples arrive as one-cycle valid strobes in the core clock domain.
`timescale 1ns/10ps
module brs_lpf
	import brs_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Sample in
	input wire brs_sample_t i_sample,
	input wire logic [15:0] i_coef,
	// Filtered out
	output logic [W-1:0] o_filt
);

	logic [W+15:0] acc_r;
	logic [W+15:0] acc_nxt;
	logic signed [W+1:0] diff;
	logic signed [W+17:0] step;
	logic [15:0] coef;

	always_comb begin
		coef = {i_coef[15:BRS_LPF_LSB], 3'h0};
		// Clamp so that values above unity never overshoot
		if (coef > BRS_LPF_UNITY) begin
			coef = BRS_LPF_UNITY;
		end
		diff = $signed({2'b00, i_sample.volt}) - $signed({2'b00, acc_r[W+13:14]});
		step = diff * $signed({2'b00, coef});
		acc_nxt = acc_r;
		if (i_sample.valid) begin
			// Coefficient 0 freezes output, 4000h passes input as is
			acc_nxt = (W+16)'($signed({2'b00, acc_r}) + step);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	assign o_filt = acc_r[W+13:BRS_LPF_SHIFT];

endmodule

// file: rtl/brs_pkg.sv
// Package for the battery rail selection block: register map, field positions,
// reset values, filter constants and the per-channel carrier types.
// Assumes a 32-bit APB register bus and a 200 MHz core clock.
package brs_pkg;

	// Register byte addresses (printed offset 0x05 is not a multiple of four, so it is an index)
	localparam logic [7:0] BRS_RELAY_IDX = 8'h05;
	localparam logic [11:0] BRS_RELAY_ADDR = 12'h014;
	localparam logic [11:0] BRS_HTH_ADDR = 12'h020;
	localparam logic [11:0] BRS_LTH_ADDR = 12'h024;
	localparam logic [11:0] BRS_LPF_ADDR = 12'h028;
	localparam logic [11:0] BRS_STATE_ADDR = 12'h02c;
	localparam logic [11:0] BRS_VOLT_A_ADDR = 12'h030;
	localparam logic [11:0] BRS_VOLT_B_ADDR = 12'h034;

	// Relay control fields
	localparam int BRS_AUTO_BIT = 0;
	localparam int BRS_THIRD_RAIL_PRESENT_BIT = 1;
	localparam int BRS_GPO_BIT = 4;
	localparam int BRS_MANUAL_RAIL_BIT_BIT = 5;

	// Threshold field
	localparam int BRS_TH_MSB = 14;
	localparam int BRS_TH_LSB = 7;

	// Filter: coefficient LSBs below bit 3 unused, 4000h is unity gain
	localparam int BRS_LPF_LSB = 3;
	localparam logic [15:0] BRS_LPF_UNITY = 16'h4000;
	localparam int BRS_LPF_SHIFT = 14;

	// Filter update rate: 800 Hz sample rate derived from 200 MHz
	localparam int BRS_CLK_HZ = 200000000;
	localparam int BRS_SAMPLE_HZ = 800;
	localparam int BRS_SAMPLE_CYC = BRS_CLK_HZ / BRS_SAMPLE_HZ;

	// Reset values
	localparam logic [7:0] BRS_RELAY_RST = 8'h01;
	localparam logic [15:0] BRS_HTH_RST = 16'h0000;
	localparam logic [15:0] BRS_LTH_RST = 16'h0000;
	localparam logic [15:0] BRS_LPF_RST = 16'h0a10;

	// Line state per channel
	typedef enum logic [1:0] {
		BRS_LINE_ONHOOK = 2'h0,
		BRS_LINE_RINGING = 2'h1,
		BRS_LINE_OFFHOOK = 2'h2,
		BRS_LINE_OHT = 2'h3
	} brs_line_t;

	typedef struct packed {
		logic [15:0] volt;
		logic valid;
	} brs_sample_t;

	typedef struct packed {
		brs_line_t line;
		logic ring_active;
	} brs_status_t;

endpackage

// file: rtl/brs_top.sv
// Battery rail selection for a dual-channel line interface: APB registers,
// sample pacing, per-channel filtering and hysteretic rail choice.
// Assumes line state and voltage arrive synchronous to i_core_clk from the line monitor.
//
// Notes on behaviour
// - Select low drives low rail, high drives high.
// - On-hook uses ringing-capable rail; off-hook goes low.
// - Watch voltage; pick lowest workable rail off-hook.
// - Relay bit drives both selects; auto mode optional.
// - Above high threshold go back to high rail.
// - At low threshold move to low rail.
// - Coefficient scaled by 4096/800 times eight.
// - Zero blocks, 4000h passes unfiltered.
// - Thresholds sit in bits 14:7 of words.
// - Third rail present: ringing cadence drives output.
`timescale 1ns/10ps
module brs_top
	import brs_pkg::*;
#(
	parameter int NCH = 2,
	parameter int SAMPLE_CYC = BRS_SAMPLE_CYC
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Line monitor, per channel
	input wire logic [15:0] i_tip_ring_volt [NCH],
	input wire brs_status_t i_line_status [NCH],
	// Rail switches
	output logic o_rail_select_out_ch_a,
	output logic o_rail_select_out_ch_b,
	output logic o_ringing_rail_switch_out
);

	logic [7:0] relay_r;
	logic [7:0] relay_nxt;
	logic [15:0] hth_r;
	logic [15:0] hth_nxt;
	logic [15:0] lth_r;
	logic [15:0] lth_nxt;
	logic [15:0] lpf_r;
	logic [15:0] lpf_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic [$clog2(SAMPLE_CYC)-1:0] div_r;
	logic [$clog2(SAMPLE_CYC)-1:0] div_nxt;
	logic tick;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic auto_en;
	logic third_rail_present;
	logic [15:0] filt [NCH];
	logic [NCH-1:0] sel_r;
	logic [NCH-1:0] sel_nxt;
	logic [NCH-1:0] ringing;
	logic gpo_r;
	logic gpo_nxt;

	// Setup-then-access APB: answer in the first access cycle, no wait states
	assign wr_en = i_psel && i_penable && i_pwrite;
	assign rd_en = i_psel && !i_penable && !i_pwrite;
	assign o_pready = 1'b1;
	assign auto_en = relay_r[BRS_AUTO_BIT];
	assign third_rail_present = relay_r[BRS_THIRD_RAIL_PRESENT_BIT];

	always_comb begin
		hit = 1'b1;
		case (i_paddr)
			BRS_RELAY_ADDR, BRS_HTH_ADDR, BRS_LTH_ADDR, BRS_LPF_ADDR,
			BRS_STATE_ADDR, BRS_VOLT_A_ADDR, BRS_VOLT_B_ADDR: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		relay_nxt = relay_r;
		hth_nxt = hth_r;
		lth_nxt = lth_r;
		lpf_nxt = lpf_r;
		if (wr_en) begin
			case (i_paddr)
				BRS_RELAY_ADDR: begin
					relay_nxt = i_pwdata[7:0];
				end
				BRS_HTH_ADDR: begin
					hth_nxt = {1'b0, i_pwdata[BRS_TH_MSB:BRS_TH_LSB], 7'h00};
				end
				BRS_LTH_ADDR: begin
					lth_nxt = {1'b0, i_pwdata[BRS_TH_MSB:BRS_TH_LSB], 7'h00};
				end
				BRS_LPF_ADDR: begin
					lpf_nxt = {i_pwdata[15:BRS_LPF_LSB], 3'h0};
				end
				default: begin
				end
			endcase
		end
		// Status bits reflect hardware: select indicator and ringing output.
		// Keyed on the next auto bit, so the write that leaves auto mode also sets the manual bit.
		relay_nxt[BRS_MANUAL_RAIL_BIT_BIT] = relay_nxt[BRS_AUTO_BIT] ? sel_r[0] : relay_nxt[BRS_MANUAL_RAIL_BIT_BIT];
		relay_nxt[BRS_GPO_BIT] = gpo_r;
	end

	always_comb begin
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (rd_en) begin
			case (i_paddr)
				BRS_RELAY_ADDR: prdata_nxt = {24'h000000, relay_r};
				BRS_HTH_ADDR: prdata_nxt = {16'h0000, hth_r};
				BRS_LTH_ADDR: prdata_nxt = {16'h0000, lth_r};
				BRS_LPF_ADDR: prdata_nxt = {16'h0000, lpf_r};
				BRS_STATE_ADDR: prdata_nxt = {28'h0000000, gpo_r, 1'b0, sel_r[1], sel_r[0]};
				BRS_VOLT_A_ADDR: prdata_nxt = {16'h0000, filt[0]};
				BRS_VOLT_B_ADDR: prdata_nxt = {16'h0000, filt[1]};
				default: prdata_nxt = 32'h00000000;
			endcase
		end
		if (i_psel && !i_penable) begin
			pslverr_nxt = !hit;
		end else if (i_psel) begin
			pslverr_nxt = pslverr_r;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			relay_r <= BRS_RELAY_RST;
			hth_r <= BRS_HTH_RST;
			lth_r <= BRS_LTH_RST;
			lpf_r <= BRS_LPF_RST;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			relay_r <= relay_nxt;
			hth_r <= hth_nxt;
			lth_r <= lth_nxt;
			lpf_r <= lpf_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign o_prdata = prdata_r;
	assign o_pslverr = pslverr_r && i_psel && i_penable;

	// Sample pacing at the filter rate; the coefficient scaling assumes this rate
	always_comb begin
		div_nxt = div_r + 1'b1;
		tick = 1'b0;
		if (div_r == ($clog2(SAMPLE_CYC))'(SAMPLE_CYC - 1)) begin
			div_nxt = '0;
			tick = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end

	// Per-channel filtering and rail choice
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		brs_sample_t smp;
		logic offhook;

		assign smp = {i_tip_ring_volt[c], tick};
		assign offhook = (i_line_status[c].line == BRS_LINE_OFFHOOK);
		assign ringing[c] = i_line_status[c].ring_active;

		brs_lpf #(
			.W(16)
		) u_lpf (
			.i_core_clk(i_core_clk),
			.i_resetn(i_resetn),
			.i_sample(smp),
			.i_coef(lpf_r),
			.o_filt(filt[c])
		);

		always_comb begin
			sel_nxt[c] = sel_r[c];
			if (!auto_en) begin
				sel_nxt[c] = relay_r[BRS_MANUAL_RAIL_BIT_BIT];
			end else if (!offhook) begin
				// On-hook, ringing and on-hook transmission stay on the high rail
				sel_nxt[c] = 1'b1;
			end else if (sel_r[c] && filt[c] <= lth_r) begin
				sel_nxt[c] = 1'b0;
			end else if (!sel_r[c] && filt[c] >= hth_r) begin
				sel_nxt[c] = 1'b1;
			end
			// Between the thresholds the previous choice holds
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_r <= {NCH{1'b1}};
		end else begin
			sel_r <= sel_nxt;
		end
	end

	always_comb begin
		gpo_nxt = relay_r[BRS_GPO_BIT];
		if (third_rail_present) begin
			gpo_nxt = |ringing;
		end else begin
			gpo_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			gpo_r <= 1'b0;
		end else begin
			gpo_r <= gpo_nxt;
		end
	end

	// Low selects the low rail, high the high rail
	assign o_rail_select_out_ch_a = sel_r[0];
	assign o_rail_select_out_ch_b = sel_r[1];
	assign o_ringing_rail_switch_out = gpo_r;

endmodule
